// *** rtl/smthr_pkg.sv ***
package smthr_pkg;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_SMART = 8'hB0;
    localparam logic [7:0] SUB_READ_THR = 8'hD1;
    localparam logic [7:0] SUB_RETURN_STATUS = 8'hDA;
    localparam logic [7:0] CYL_LO_SIG = 8'h4F;
    localparam logic [7:0] CYL_HI_SIG = 8'hC2;
    localparam logic [7:0] CYL_LO_EXCEEDED = 8'hF4;
    localparam logic [7:0] CYL_HI_EXCEEDED = 8'h2C;

    // ------------------------------------------------------------
    // Sector layout
    // ------------------------------------------------------------
    localparam int SECTOR_BYTES = 512;
    localparam logic [8:0] BYTE_LAST = 9'h1FF;
    localparam logic [15:0] STRUCT_VERSION = 16'h0004;
    localparam logic [8:0] ENTRY_FIRST = 9'h002;
    localparam logic [8:0] ENTRY_END = 9'h16A;
    localparam logic [3:0] ENTRY_BYTES = 4'hC;
    localparam logic [4:0] ENTRY_COUNT_USED = 5'h06;

    // ------------------------------------------------------------
    // Attribute identifiers, in entry order
    // ------------------------------------------------------------
    localparam logic [7:0] ATTR_SPARE = 8'hC4;
    localparam logic [7:0] ATTR_ERASE = 8'hE5;
    localparam logic [7:0] ATTR_ECC_TOTAL = 8'hCB;
    localparam logic [7:0] ATTR_ECC_CORR = 8'hCC;
    localparam logic [7:0] ATTR_READS = 8'hE8;
    localparam logic [7:0] ATTR_UDMA_CRC = 8'hC7;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CYL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    typedef enum logic [1:0] {
        SMTHR_IDLE = 2'b00,
        SMTHR_SEND = 2'b01,
        SMTHR_DONE = 2'b11
    } smthr_state_t;

endpackage : smthr_pkg

// *** rtl/smthr_skid.sv ***
`timescale 1ns/1ps
module smthr_skid
    import smthr_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Filling side
    input wire logic i_valid,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_ready,
    // Draining side
    output logic o_valid,
    output logic [WIDTH-1:0] o_data,
    input wire logic i_ready
);

    // Two entries so a receiver stall loses no word
    logic [WIDTH-1:0] mem_reg [2];
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    logic [1:0] count_reg;
    logic push;
    logic pop;

    assign o_ready = (count_reg != 2'h2);
    assign o_valid = (count_reg != 2'h0);
    assign o_data = mem_reg[rd_ptr_reg];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            count_reg <= 2'(count_reg + {1'b0, push} - {1'b0, pop});
        end
    end

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= i_data;
        end
    end

endmodule : smthr_skid

// *** rtl/smthr_cmd.sv ***
`timescale 1ns/1ps
module smthr_cmd
    import smthr_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Task file command, one-cycle strobe
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd,
    input wire logic [7:0] i_features,
    input wire logic [7:0] i_cyl_lo,
    input wire logic [7:0] i_cyl_hi,
    // Attribute values and thresholds from the card controller
    input wire logic [7:0] i_spare_value,
    input wire logic [7:0] i_spare_thresh,
    input wire logic [7:0] i_erase_value,
    input wire logic [7:0] i_erase_thresh,
    // Sector data stream
    output logic o_data_valid,
    output logic [7:0] o_data,
    output logic o_data_last,
    input wire logic i_data_ready,
    // Command results
    output logic o_busy,
    output logic o_done,
    output logic o_abort,
    output logic [7:0] o_cyl_lo,
    output logic [7:0] o_cyl_hi
);

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic sig_ok;
    logic is_smart;
    logic start_read;
    logic start_status;
    logic exceeded;
    logic busy_reg;
    logic read_go;

    assign sig_ok = (i_cyl_lo == CYL_LO_SIG) && (i_cyl_hi == CYL_HI_SIG);
    assign is_smart = i_cmd_valid && (i_cmd == CMD_SMART) && sig_ok;
    assign start_read = is_smart && (i_features == SUB_READ_THR);
    assign start_status = is_smart && (i_features == SUB_RETURN_STATUS);
    // Busy covers the drain too, so a read while bytes drain cannot restart the sector
    assign read_go = start_read && !busy_reg;
    // Strict less-than on both monitored attributes
    assign exceeded = (i_spare_value < i_spare_thresh)
        || (i_erase_value < i_erase_thresh);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    smthr_state_t state_reg;
    logic [8:0] idx_reg;
    logic [7:0] sum_reg;
    logic [7:0] spare_thr_reg;
    logic [7:0] erase_thr_reg;
    logic [7:0] byte_next;
    logic push_ready;
    logic push;
    logic [8:0] rel;
    logic [4:0] entry;
    logic [3:0] eoff;
    logic [7:0] entry_id;
    logic [7:0] entry_thr;

    assign push = (state_reg == SMTHR_SEND) && push_ready;

    // Entry number and byte offset inside the entry area
    always_comb begin
        rel = 9'(idx_reg - ENTRY_FIRST);
        entry = 5'(rel / 9'(ENTRY_BYTES));
        eoff = 4'(rel % 9'(ENTRY_BYTES));
    end

    always_comb begin
        case (entry)
            5'h00: begin
                entry_id = ATTR_SPARE;
                entry_thr = spare_thr_reg;
            end
            5'h01: begin
                entry_id = ATTR_ERASE;
                entry_thr = erase_thr_reg;
            end
            5'h02: begin
                entry_id = ATTR_ECC_TOTAL;
                entry_thr = BYTE_RESET;
            end
            5'h03: begin
                entry_id = ATTR_ECC_CORR;
                entry_thr = BYTE_RESET;
            end
            5'h04: begin
                entry_id = ATTR_READS;
                entry_thr = BYTE_RESET;
            end
            5'h05: begin
                entry_id = ATTR_UDMA_CRC;
                entry_thr = BYTE_RESET;
            end
            default: begin
                // Unused entries stay all zero
                entry_id = BYTE_RESET;
                entry_thr = BYTE_RESET;
            end
        endcase
    end

    // Byte generator for the sector
    always_comb begin
        byte_next = BYTE_RESET;
        if (idx_reg == 9'h000) begin
            byte_next = STRUCT_VERSION[7:0];
        end else if (idx_reg == 9'h001) begin
            byte_next = STRUCT_VERSION[15:8];
        end else if (idx_reg < ENTRY_END && entry < ENTRY_COUNT_USED) begin
            if (eoff == 4'h0) begin
                byte_next = entry_id;
            end else if (eoff == 4'h1) begin
                byte_next = entry_thr;
            end
        end else if (idx_reg == BYTE_LAST) begin
            byte_next = 8'(8'h00 - sum_reg);
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg <= SMTHR_IDLE;
        end else begin
            case (state_reg)
                SMTHR_IDLE: begin
                    if (read_go) begin
                        state_reg <= SMTHR_SEND;
                    end
                end
                SMTHR_SEND: begin
                    if (push && idx_reg == BYTE_LAST) begin
                        state_reg <= SMTHR_DONE;
                    end
                end
                SMTHR_DONE: begin
                    state_reg <= SMTHR_IDLE;
                end
                default: begin
                    state_reg <= SMTHR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            idx_reg <= 9'h000;
            sum_reg <= BYTE_RESET;
        end else if (read_go) begin
            idx_reg <= 9'h000;
            sum_reg <= BYTE_RESET;
        end else if (push) begin
            idx_reg <= 9'(idx_reg + 9'h001);
            sum_reg <= 8'(sum_reg + byte_next);
        end
    end

    // Thresholds frozen for the whole sector so the checksum holds
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            spare_thr_reg <= BYTE_RESET;
            erase_thr_reg <= BYTE_RESET;
        end else if (read_go) begin
            spare_thr_reg <= i_spare_thresh;
            erase_thr_reg <= i_erase_thresh;
        end
    end

    // ------------------------------------------------------------
    // Output buffer
    // ------------------------------------------------------------
    logic buf_valid;
    logic [8:0] buf_data;
    logic out_valid_reg;
    logic [7:0] out_data_reg;
    logic out_last_reg;
    logic out_take;

    smthr_skid #(
        .WIDTH(9)
    ) u_skid (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_valid(state_reg == SMTHR_SEND),
        .i_data({idx_reg == BYTE_LAST, byte_next}),
        .o_ready(push_ready),
        .o_valid(buf_valid),
        .o_data(buf_data),
        .i_ready(out_take)
    );

    // Registered output stage keeps outputs straight from flops
    assign out_take = !out_valid_reg || i_data_ready;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            out_valid_reg <= 1'b0;
            out_data_reg <= BYTE_RESET;
            out_last_reg <= 1'b0;
        end else if (out_take) begin
            out_valid_reg <= buf_valid;
            out_data_reg <= buf_data[7:0];
            out_last_reg <= buf_valid && buf_data[8];
        end
    end

    assign o_data_valid = out_valid_reg;
    assign o_data = out_data_reg;
    assign o_data_last = out_last_reg;

    // ------------------------------------------------------------
    // Results
    // ------------------------------------------------------------
    logic done_reg;
    logic abort_reg;
    logic [7:0] cyl_lo_reg;
    logic [7:0] cyl_hi_reg;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            busy_reg <= 1'b0;
        end else if (read_go) begin
            busy_reg <= 1'b1;
        end else if (out_valid_reg && out_last_reg && i_data_ready) begin
            busy_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            done_reg <= 1'b0;
            abort_reg <= 1'b0;
            cyl_lo_reg <= CYL_RESET;
            cyl_hi_reg <= CYL_RESET;
        end else begin
            done_reg <= 1'b0;
            abort_reg <= 1'b0;
            if (busy_reg && out_valid_reg && out_last_reg && i_data_ready) begin
                done_reg <= 1'b1;
            end
            if (start_status && !busy_reg) begin
                done_reg <= 1'b1;
                if (exceeded) begin
                    cyl_lo_reg <= CYL_LO_EXCEEDED;
                    cyl_hi_reg <= CYL_HI_EXCEEDED;
                end else begin
                    cyl_lo_reg <= CYL_LO_SIG;
                    cyl_hi_reg <= CYL_HI_SIG;
                end
            end else if (i_cmd_valid && !read_go) begin
                // Other command, unknown subcommand, bad signature or busy: reject
                abort_reg <= 1'b1;
            end
        end
    end

    assign o_busy = busy_reg;
    assign o_done = done_reg;
    assign o_abort = abort_reg;
    assign o_cyl_lo = cyl_lo_reg;
    assign o_cyl_hi = cyl_hi_reg;

endmodule : smthr_cmd

// *** tb/smthr_cmd_properties.sv ***
`timescale 1ns/1ps
module smthr_cmd_properties
    import smthr_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Command and attributes
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd,
    input wire logic [7:0] i_features,
    input wire logic [7:0] i_cyl_lo,
    input wire logic [7:0] i_cyl_hi,
    input wire logic [7:0] i_spare_value,
    input wire logic [7:0] i_spare_thresh,
    input wire logic [7:0] i_erase_value,
    input wire logic [7:0] i_erase_thresh,
    // Stream and results
    input wire logic o_data_valid,
    input wire logic [7:0] o_data,
    input wire logic o_data_last,
    input wire logic i_data_ready,
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic o_abort,
    input wire logic [7:0] o_cyl_lo,
    input wire logic [7:0] o_cyl_hi
);
    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    logic [8:0] hs_cnt_reg;
    logic [7:0] hs_sum_reg;
    logic hs, sig_ok, rd_go, st_go, over;
    assign hs = o_data_valid && i_data_ready;
    assign sig_ok = i_cmd == 8'hB0 && i_cyl_lo == 8'h4F && i_cyl_hi == 8'hC2;
    assign rd_go = i_cmd_valid && sig_ok && i_features == 8'hD1 && !o_busy;
    assign st_go = i_cmd_valid && sig_ok && i_features == 8'hDA && !o_busy;
    assign over = (i_spare_value < i_spare_thresh) || (i_erase_value < i_erase_thresh);

    // Running byte index and sum, cleared after the last byte of a sector
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hs_cnt_reg <= 9'h000;
            hs_sum_reg <= 8'h00;
        end else if (hs) begin
            hs_cnt_reg <= o_data_last ? 9'h000 : hs_cnt_reg + 9'h001;
            hs_sum_reg <= o_data_last ? 8'h00 : hs_sum_reg + o_data;
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    property p_read_busy; rd_go |=> o_busy && !o_abort && !o_done; endproperty
    a_read_busy: assert property (p_read_busy) else $error("read not taken");
    property p_first_byte; rd_go |-> ##3 o_data_valid && o_data == 8'h04; endproperty
    a_first_byte: assert property (p_first_byte) else $error("first byte wrong");
    property p_last_pos; hs && o_data_last |-> hs_cnt_reg == 9'h1FF; endproperty
    a_last_pos: assert property (p_last_pos) else $error("last flag misplaced");
    property p_checksum; hs && o_data_last |-> 8'(hs_sum_reg + o_data) == 8'h00; endproperty
    a_checksum: assert property (p_checksum) else $error("sector sum not zero");
    property p_read_done; hs && o_data_last |=> o_done && !o_busy && !o_data_valid; endproperty
    a_read_done: assert property (p_read_done) else $error("read did not finish");
    property p_hold; o_data_valid && !i_data_ready |=> o_data_valid && $stable(o_data); endproperty
    a_hold: assert property (p_hold) else $error("stalled byte lost");
    property p_st_over; st_go && over |=> o_done && o_cyl_lo == 8'hF4 && o_cyl_hi == 8'h2C; endproperty
    a_st_over: assert property (p_st_over) else $error("exceeded status wrong");
    property p_st_ok; st_go && !over |=> o_done && o_cyl_lo == 8'h4F && o_cyl_hi == 8'hC2; endproperty
    a_st_ok: assert property (p_st_ok) else $error("good status wrong");
    property p_refuse;
        i_cmd_valid && !rd_go && !st_go |=> o_abort && !o_done && $stable(o_cyl_lo) && $stable(o_cyl_hi);
    endproperty
    a_refuse: assert property (p_refuse) else $error("bad command not refused");
endmodule : smthr_cmd_properties

bind smthr_cmd smthr_cmd_properties i_smthr_cmd_properties (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_features(i_features), .i_cyl_lo(i_cyl_lo),
    .i_cyl_hi(i_cyl_hi), .i_spare_value(i_spare_value), .i_spare_thresh(i_spare_thresh),
    .i_erase_value(i_erase_value), .i_erase_thresh(i_erase_thresh), .o_data_valid(o_data_valid),
    .o_data(o_data), .o_data_last(o_data_last), .i_data_ready(i_data_ready), .o_busy(o_busy),
    .o_done(o_done), .o_abort(o_abort), .o_cyl_lo(o_cyl_lo), .o_cyl_hi(o_cyl_hi));

// *** tb/smthr_host_sink.sv ***
`timescale 1ns/1ps
module smthr_host_sink (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Bench control
    input wire logic i_clear,
    input wire logic i_slow,
    input wire logic i_hold,
    // Sector stream
    input wire logic i_valid,
    input wire logic [7:0] i_data,
    output logic o_ready,
    // Capture
    output logic [9:0] o_count
);
    logic [7:0] mem [0:511];
    logic [1:0] phase_reg;

    // Slow mode takes one byte in four, so the buffer must hold its word
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            phase_reg <= 2'h0;
            o_ready <= 1'b0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
            o_ready <= !i_hold && (!i_slow || phase_reg == 2'h2);
        end
    end

    // A count past one sector shows an overrun
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_count <= 10'h000;
        end else if (i_clear) begin
            o_count <= 10'h000;
        end else if (i_valid && o_ready) begin
            if (o_count < 10'h200) begin
                mem[o_count[8:0]] <= i_data;
            end
            o_count <= o_count + 10'h001;
        end
    end
endmodule : smthr_host_sink

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
    import smthr_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_arst_n, i_cmd_valid, i_data_ready, i_clear, i_slow, i_hold;
    logic [7:0] i_cmd, i_features, i_cyl_lo, i_cyl_hi;
    logic [7:0] i_spare_value, i_spare_thresh, i_erase_value, i_erase_thresh;
    logic o_data_valid, o_data_last, o_busy, o_done, o_abort;
    logic [7:0] o_data, o_cyl_lo, o_cyl_hi;
    logic [9:0] count;
    int failures = 0;
    int checks = 0;
    int cycles = 0;

    smthr_cmd i_smthr_cmd (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
        .i_features(i_features), .i_cyl_lo(i_cyl_lo), .i_cyl_hi(i_cyl_hi), .i_spare_value(i_spare_value),
        .i_spare_thresh(i_spare_thresh), .i_erase_value(i_erase_value), .i_erase_thresh(i_erase_thresh),
        .o_data_valid(o_data_valid), .o_data(o_data), .o_data_last(o_data_last), .i_data_ready(i_data_ready),
        .o_busy(o_busy), .o_done(o_done), .o_abort(o_abort), .o_cyl_lo(o_cyl_lo), .o_cyl_hi(o_cyl_hi));
    smthr_host_sink i_smthr_host_sink (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_clear(i_clear), .i_slow(i_slow),
        .i_hold(i_hold), .i_valid(o_data_valid), .i_data(o_data), .o_ready(i_data_ready), .o_count(count));

    always #50 i_clk = ~i_clk;

    // Three sectors, one of them at one byte in four, stay well under this ceiling
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            give_verdict();
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic give_verdict();
        if (failures == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp8

    task automatic cmp1(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask : cmp1

    task automatic issue(input logic [7:0] c, f, lo, hi);
        @(posedge i_clk);
        i_cmd_valid <= 1'b1;
        i_cmd <= c;
        i_features <= f;
        i_cyl_lo <= lo;
        i_cyl_hi <= hi;
        @(posedge i_clk);
        i_cmd_valid <= 1'b0;
        #1;
    endtask : issue

    task automatic wait_done();
        int n;
        n = 0;
        while (o_done !== 1'b1 && n < 4000) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        cmp1("done", 1'b1, o_done);
    endtask : wait_done

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_status(input logic [7:0] sv, st, ev, et);
        logic over;
        over = (sv < st) || (ev < et);
        @(posedge i_clk);
        i_spare_value <= sv;
        i_spare_thresh <= st;
        i_erase_value <= ev;
        i_erase_thresh <= et;
        issue(8'hB0, 8'hDA, 8'h4F, 8'hC2);
        cmp1("status done", 1'b1, o_done);
        cmp8("cyl low", over ? 8'hF4 : 8'h4F, o_cyl_lo);
        cmp8("cyl high", over ? 8'h2C : 8'hC2, o_cyl_hi);
    endtask : t_status

    task automatic t_read(input logic [7:0] ts, te, input logic sl);
        logic [7:0] ids [0:5] = '{8'hC4, 8'hE5, 8'hCB, 8'hCC, 8'hE8, 8'hC7};
        logic [7:0] exp [0:511];
        logic [7:0] sum;
        int i;
        sum = 8'h00;
        for (i = 0; i < 512; i++) exp[i] = 8'h00;
        exp[0] = 8'h04;
        for (i = 0; i < 6; i++) exp[2 + 12 * i] = ids[i];
        exp[3] = ts;
        exp[15] = te;
        for (i = 0; i < 511; i++) sum += exp[i];
        exp[511] = 8'h00 - sum;
        @(posedge i_clk);
        i_spare_thresh <= ts;
        i_erase_thresh <= te;
        i_slow <= sl;
        i_clear <= 1'b1;
        @(posedge i_clk);
        i_clear <= 1'b0;
        issue(8'hB0, 8'hD1, 8'h4F, 8'hC2);
        cmp1("busy", 1'b1, o_busy);
        wait_done();
        cmp1("one sector", 1'b1, count === 10'h200);
        for (i = 0; i < 512; i++) cmp8("sector byte", exp[i], i_smthr_host_sink.mem[i]);
    endtask : t_read

    task automatic refuse_one(input logic [7:0] c, f, lo, hi);
        logic [7:0] lo_was;
        lo_was = o_cyl_lo;
        issue(c, f, lo, hi);
        cmp1("abort", 1'b1, o_abort);
        cmp1("no done", 1'b0, o_done);
        cmp8("cyl kept", lo_was, o_cyl_lo);
    endtask : refuse_one

    task automatic t_refuse();
        refuse_one(8'hEC, 8'hDA, 8'h4F, 8'hC2);
        refuse_one(8'hB0, 8'hD0, 8'h4F, 8'hC2);
        refuse_one(8'hB0, 8'hD1, 8'h4E, 8'hC2);
        refuse_one(8'hB0, 8'hDA, 8'h4F, 8'hC3);
        @(posedge i_clk);
        i_hold <= 1'b1;
        issue(8'hB0, 8'hD1, 8'h4F, 8'hC2);
        refuse_one(8'hB0, 8'hDA, 8'h4F, 8'hC2);
        refuse_one(8'hB0, 8'hD1, 8'h4F, 8'hC2);
        @(posedge i_clk);
        i_hold <= 1'b0;
        wait_done();
    endtask : t_refuse

    initial begin
        i_arst_n = 1'b0;
        {i_cmd_valid, i_clear, i_slow, i_hold} = 4'h0;
        {i_cmd, i_features, i_cyl_lo, i_cyl_hi} = 32'h0;
        {i_spare_value, i_spare_thresh, i_erase_value, i_erase_thresh} = 32'h0;
        repeat (6) @(posedge i_clk);
        i_arst_n <= 1'b1;
        t_status(8'h05, 8'h06, 8'h32, 8'h32);
        t_status(8'h06, 8'h06, 8'h32, 8'h32);
        t_status(8'h32, 8'h32, 8'h09, 8'h0A);
        t_status(8'h32, 8'h32, 8'h0A, 8'h0A);
        t_status(8'hFF, 8'h00, 8'h00, 8'h00);
        t_read(8'h0A, 8'h05, 1'b1);
        t_read(8'hFF, 8'h00, 1'b0);
        t_refuse();
        give_verdict();
    end
endmodule : tb_top
